// [core/burst_sram_map.svh]
// constants of the pipelined burst memory control block
`ifndef BURST_SRAM_MAP_SVH
`define BURST_SRAM_MAP_SVH

`define BSR_ADDR_W     19
`define BSR_HI_W       17
`define BSR_BEAT_W     2
`define BSR_DATA_W     32
`define BSR_LANES      4
`define BSR_LANE_W     8
`define BSR_WORD_W     36
`define BSR_WORDS      524288

`define BSR_CNT_ZERO   2'h0
`define BSR_CNT_STEP   2'h1
`define BSR_CNT_LAST   2'h3
`define BSR_MASK_NONE  4'hf

`define BSR_CLK_NS     40
`define BSR_ZZ_ENTRY_CYC     2
`define BSR_ZZ_RECOVERY_CYC  2

`endif

// [core/burst_sram_pkg.sv]
// types shared by the burst memory control files
package burst_sram_pkg;

  // gray order: idle -> read -> write -> sleep
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b11,
    ST_SLEEP = 2'b10
  } burst_state_e;

  typedef enum logic [1:0] {
    PO_NONE  = 2'b00,
    PO_READ  = 2'b01,
    PO_WRITE = 2'b11
  } pipe_op_e;

endpackage

// [core/burst_addr_step.sv]
// two-bit burst address sequencer, interleaved or linear
module burst_addr_step (
  // burst position
  input  wire logic [1:0] start_low,
  input  wire logic [1:0] count,
  // strap: high selects interleaved order
  input  wire logic       interleaved,
  // address bits for this beat
  output logic      [1:0] beat_low
);

  always_comb begin
    if (interleaved) begin
      beat_low = start_low ^ count; // [RULE_01]
    end else begin
      beat_low = 2'(start_low + count); // [RULE_02]
    end
  end

endmodule // burst_addr_step

// [core/pipelined_burst_sram.sv]
// pipelined burst static memory: decode, burst counter, write masks, drivers
// Behaviour
// [RULE_01] strap high: interleaved XOR burst order
// [RULE_02] strap low: linear modulo-four burst order
// [RULE_03] load with enables, write high starts read
// [RULE_04] advance continues burst, ignores enables, write
// [RULE_05] read without output enable stays three-stated
// [RULE_06] load with enables, write low starts write
// [RULE_07] all lanes masked in burst: advance, no store
// [RULE_08] all lanes masked at start: no-operation
// [RULE_09] each lane select stores lane plus parity
// [RULE_10] clock qualify high freezes everything; sleep entry and exit still proceed
// [RULE_11] any chip enable inactive means deselect
// [RULE_12] write cycles three-state all data lines
// [RULE_13] data phase operation sets driver state
// [RULE_14] reset leaves deselected, lines three-stated
// [RULE_15] output enable acts combinationally on drivers
// [RULE_16] output enable masked during writes
// [RULE_17] sleep within two clocks, ignores inputs
// [RULE_18] advance steps counter; burst type latched
// [RULE_19] read data appears one edge later
// [RULE_20] write data presented at second edge
// [RULE_21] controller deselects around sleep
// [RULE_22] counter wraps and repeats four beats
`include "burst_sram_map.svh"

module pipelined_burst_sram (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // address and control
  input  wire logic [`BSR_ADDR_W-1:0] addr,
  input  wire logic                   chip_en1_n,
  input  wire logic                   chip_en2,
  input  wire logic                   chip_en3_n,
  input  wire logic                   advance_or_load,
  input  wire logic                   write_en_n,
  input  wire logic [`BSR_LANES-1:0]  byte_lane_write_n,
  input  wire logic                   out_en_n,
  input  wire logic                   clock_qualify_n,
  input  wire logic                   sleep_request,
  input  wire logic                   burst_mode,
  // data lines
  input  wire logic [`BSR_DATA_W-1:0] dq_in,
  output logic      [`BSR_DATA_W-1:0] dq_out,
  output logic                        dq_oe,
  // parity lines
  input  wire logic [`BSR_LANES-1:0]  parity_in,
  output logic      [`BSR_LANES-1:0]  parity_out,
  output logic                        parity_oe,
  // status
  output logic                        asleep
);
  import burst_sram_pkg::*;

  // one write-enable bit per stored bit, parity lanes on top
  function automatic logic [`BSR_WORD_W-1:0] lane_enables(
    input logic [`BSR_LANES-1:0] mask_n
  );
    logic [`BSR_WORD_W-1:0] en;
    en = '0;
    for (int i = 0; i < `BSR_LANES; i++) begin
      en[i*`BSR_LANE_W +: `BSR_LANE_W] = {`BSR_LANE_W{~mask_n[i]}};
      en[`BSR_DATA_W + i] = ~mask_n[i];
    end
    return en;
  endfunction

  function automatic logic [`BSR_WORD_W-1:0] lane_merge(
    input logic [`BSR_WORD_W-1:0] old_word,
    input logic [`BSR_WORD_W-1:0] new_word,
    input logic [`BSR_LANES-1:0]  mask_n
  );
    logic [`BSR_WORD_W-1:0] en;
    en = lane_enables(mask_n);
    return (old_word & ~en) | (new_word & en); // [RULE_09]
  endfunction

  logic [`BSR_WORD_W-1:0] mem [0:`BSR_WORDS-1];

  burst_state_e              state_reg;
  logic [1:0]                base_reg;
  logic [1:0]                cnt_reg;
  logic [`BSR_HI_W-1:0]      hi_reg;
  logic                      sleep_seen_reg;
  logic                      asleep_reg;

  pipe_op_e                  op1_reg;
  logic [`BSR_ADDR_W-1:0]    addr1_reg;
  logic [`BSR_LANES-1:0]     mask1_reg;
  pipe_op_e                  op2_reg;
  logic [`BSR_ADDR_W-1:0]    addr2_reg;
  logic [`BSR_LANES-1:0]     mask2_reg;
  logic                      drive_reg;
  logic [`BSR_DATA_W-1:0]    dq_out_reg;
  logic [`BSR_LANES-1:0]     parity_out_reg;

  logic                      ce_all;
  logic                      run;
  logic                      load;
  logic                      adv;
  logic [1:0]                cnt_next;
  logic [1:0]                beat_low;
  logic [`BSR_ADDR_W-1:0]    acc_addr;
  pipe_op_e                  acc_op;
  logic [`BSR_WORD_W-1:0]    rd_word;
  logic [`BSR_WORD_W-1:0]    wr_word;

  assign ce_all   = !chip_en1_n && chip_en2 && !chip_en3_n;
  // sleep overrides the clock qualifier: it is honoured on every edge
  assign run      = !clock_qualify_n && !sleep_seen_reg
                    && (state_reg != ST_SLEEP); // [RULE_10] [RULE_17]
  assign load     = run && !advance_or_load;
  assign adv      = run && advance_or_load; // [RULE_04]
  assign cnt_next = 2'(cnt_reg + `BSR_CNT_STEP); // [RULE_22]

  burst_addr_step u_step (
    .start_low   (base_reg),
    .count       (cnt_next),
    .interleaved (burst_mode),
    .beat_low    (beat_low)
  );

  // address and operation entering the pipeline this edge
  always_comb begin
    acc_addr = {hi_reg, beat_low};
    acc_op   = PO_NONE;
    if (load) begin
      acc_addr = addr;
      if (ce_all) begin // [RULE_11]
        acc_op = write_en_n ? PO_READ : PO_WRITE; // [RULE_03] [RULE_06]
      end
    end else if (adv) begin
      case (state_reg) // [RULE_18]
        ST_READ:  acc_op = PO_READ;
        ST_WRITE: acc_op = PO_WRITE;
        default:  acc_op = PO_NONE;
      endcase
    end
  end

  // sleep request tracking, not gated by the clock qualifier
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sleep_seen_reg <= 1'b0;
      asleep_reg     <= 1'b0;
    end else begin
      sleep_seen_reg <= sleep_request;
      asleep_reg     <= sleep_seen_reg; // [RULE_17]
    end
  end

  // burst state and counter
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE; // [RULE_14]
      base_reg  <= `BSR_CNT_ZERO;
      cnt_reg   <= `BSR_CNT_ZERO;
      hi_reg    <= '0;
    end else if (sleep_seen_reg) begin
      state_reg <= ST_SLEEP; // [RULE_17]
    end else if (state_reg == ST_SLEEP) begin
      // leaves to deselect; enables must stay off meanwhile
      state_reg <= ST_IDLE; // [RULE_21]
    end else if (load) begin
      if (!ce_all) begin
        state_reg <= ST_IDLE; // [RULE_11]
      end else if (write_en_n) begin
        state_reg <= ST_READ; // [RULE_03]
      end else begin
        state_reg <= ST_WRITE; // [RULE_06] [RULE_08]
      end
      base_reg <= addr[`BSR_BEAT_W-1:0];
      hi_reg   <= addr[`BSR_ADDR_W-1:`BSR_BEAT_W];
      cnt_reg  <= `BSR_CNT_ZERO;
    end else if (adv) begin
      cnt_reg <= cnt_next; // [RULE_18] [RULE_22]
    end
  end

  // read data with forwarding from a write landing on the same edge
  always_comb begin
    wr_word = {parity_in, dq_in};
    rd_word = mem[addr1_reg];
    if (op2_reg == PO_WRITE && addr2_reg == addr1_reg) begin
      rd_word = lane_merge(rd_word, wr_word, mask2_reg);
    end
  end

  // address and data pipeline; a stall holds every stage
  always_ff @(posedge sys_clk) begin
    if (!resetn || sleep_seen_reg || state_reg == ST_SLEEP) begin
      op1_reg   <= PO_NONE; // [RULE_14] [RULE_17]
      op2_reg   <= PO_NONE;
      drive_reg <= 1'b0;
      addr1_reg <= '0;
      addr2_reg <= '0;
      mask1_reg <= `BSR_MASK_NONE;
      mask2_reg <= `BSR_MASK_NONE;
    end else if (run) begin // [RULE_10]
      op1_reg   <= acc_op;
      addr1_reg <= acc_addr;
      mask1_reg <= byte_lane_write_n;
      op2_reg   <= (op1_reg == PO_WRITE) ? PO_WRITE : PO_NONE;
      addr2_reg <= addr1_reg;
      mask2_reg <= mask1_reg;
      // writes and deselects leave the drivers off in their data phase
      drive_reg <= (op1_reg == PO_READ); // [RULE_12] [RULE_13] [RULE_16]
    end
  end

  // output register: read data one enabled edge after the address
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dq_out_reg     <= '0;
      parity_out_reg <= '0;
    end else if (run && op1_reg == PO_READ) begin // [RULE_19]
      dq_out_reg     <= rd_word[`BSR_DATA_W-1:0];
      parity_out_reg <= rd_word[`BSR_WORD_W-1:`BSR_DATA_W];
    end
  end

  // store: data sampled at the second enabled edge after the address
  always_ff @(posedge sys_clk) begin
    if (resetn && run && op2_reg == PO_WRITE) begin // [RULE_20]
      // an all-high mask leaves the word as it was
      mem[addr2_reg] <= lane_merge(mem[addr2_reg], wr_word, mask2_reg); // [RULE_07] [RULE_08]
    end
  end

  assign dq_out     = dq_out_reg;
  assign parity_out = parity_out_reg;
  assign asleep     = asleep_reg;
  // output enable is not registered so that drivers react within the cycle
  assign dq_oe      = drive_reg && !out_en_n; // [RULE_05] [RULE_15]
  assign parity_oe  = drive_reg && !out_en_n; // [RULE_05] [RULE_15]

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  logic awake_now;
  assign awake_now = !sleep_request && !sleep_seen_reg && state_reg != ST_SLEEP;

  il_order_a: assert property ( // [RULE_01]
    (adv && burst_mode && awake_now && state_reg == ST_READ)
    |=> (addr1_reg[1:0] == (base_reg ^ cnt_reg))
  ) else $error("interleaved burst address wrong");

  lin_order_a: assert property ( // [RULE_02]
    (adv && !burst_mode && awake_now && state_reg == ST_READ)
    |=> (addr1_reg[1:0] == 2'(base_reg + cnt_reg))
  ) else $error("linear burst address wrong");

  read_latency_a: assert property ( // [RULE_19]
    (load && ce_all && write_en_n && awake_now)
    ##1 (!clock_qualify_n && awake_now)
    |=> drive_reg && dq_out_reg == $past(rd_word[`BSR_DATA_W-1:0])
  ) else $error("read data not presented one edge later");

  stall_hold_a: assert property ( // [RULE_10]
    (clock_qualify_n && awake_now)
    |=> $stable(addr1_reg) && $stable(cnt_reg) && $stable(drive_reg)
  ) else $error("stalled edge changed state");

  write_tri_a: assert property ( // [RULE_12]
    (run && op1_reg == PO_WRITE && !sleep_request)
    |=> !dq_oe && !parity_oe
  ) else $error("drivers on in write data phase");

  sleep_enter_a: assert property ( // [RULE_17]
    sleep_request |-> ##[1:2] (state_reg == ST_SLEEP && !dq_oe)
  ) else $error("sleep not reached in two clocks");

  desel_load_a: assert property ( // [RULE_11]
    (load && !ce_all && awake_now)
    |=> op1_reg == PO_NONE && state_reg == ST_IDLE
  ) else $error("partial enables did not deselect");

  wrap_back_a: assert property ( // [RULE_22]
    (adv && cnt_reg == `BSR_CNT_LAST && awake_now)
    |=> cnt_reg == `BSR_CNT_ZERO
  ) else $error("burst counter failed to wrap");

  reset_tri_a: assert property ( // [RULE_14]
    @(posedge sys_clk) disable iff (1'b0)
    !resetn |=> !dq_oe && !parity_oe && state_reg == ST_IDLE
  ) else $error("not deselected after reset");

  burst_keep_a: assert property ( // [RULE_18]
    (adv && awake_now && state_reg == ST_WRITE)
    |=> op1_reg == PO_WRITE && state_reg == ST_WRITE
  ) else $error("burst type changed on advance");

  rd_load_a: assert property ( // [RULE_03]
    (load && ce_all && write_en_n && awake_now)
    |=> op1_reg == PO_READ && state_reg == ST_READ && addr1_reg == $past(addr)
  ) else $error("read load not taken");

  wr_load_a: assert property ( // [RULE_06]
    (load && ce_all && !write_en_n && awake_now)
    |=> op1_reg == PO_WRITE && state_reg == ST_WRITE
        && mask1_reg == $past(byte_lane_write_n)
  ) else $error("write load not taken");

  adv_read_a: assert property ( // [RULE_04]
    (adv && awake_now && state_reg == ST_READ)
    |=> op1_reg == PO_READ && state_reg == ST_READ && cnt_reg == $past(cnt_next)
  ) else $error("read burst not continued");

  il_write_a: assert property ( // [RULE_01]
    (adv && burst_mode && awake_now && state_reg == ST_WRITE)
    |=> (addr1_reg[1:0] == (base_reg ^ cnt_reg))
  ) else $error("interleaved write address wrong");

  lin_write_a: assert property ( // [RULE_02]
    (adv && !burst_mode && awake_now && state_reg == ST_WRITE)
    |=> (addr1_reg[1:0] == 2'(base_reg + cnt_reg))
  ) else $error("linear write address wrong");

  dummy_tri_a: assert property ( // [RULE_05]
    out_en_n |-> !dq_oe && !parity_oe
  ) else $error("drivers on with output enable off");

  oe_drive_a: assert property ( // [RULE_15]
    (drive_reg && !out_en_n) |-> dq_oe && parity_oe
  ) else $error("read data not driven");

  write_oe_mask_a: assert property ( // [RULE_16]
    (run && op1_reg == PO_WRITE && awake_now) ##1 !out_en_n |-> !dq_oe && !parity_oe
  ) else $error("output enable not masked in write");

  write_stage_a: assert property ( // [RULE_20]
    (run && op1_reg == PO_WRITE && awake_now)
    |=> op2_reg == PO_WRITE && addr2_reg == $past(addr1_reg) && mask2_reg == $past(mask1_reg)
  ) else $error("write did not reach store stage");

  abort_step_a: assert property ( // [RULE_07]
    (adv && awake_now && state_reg == ST_WRITE && byte_lane_write_n == `BSR_MASK_NONE)
    |=> mask1_reg == `BSR_MASK_NONE && cnt_reg == $past(cnt_next)
  ) else $error("write abort did not advance");

  asleep_flag_a: assert property ( // [RULE_17]
    sleep_request |-> ##2 asleep
  ) else $error("sleep flag late");

  data_phase_a: assert property ( // [RULE_13]
    (run && awake_now) |=> drive_reg == ($past(op1_reg) == PO_READ)
  ) else $error("driver state not from data phase");

endmodule // pipelined_burst_sram

// [verification/ctl_model.sv]
// far-side controller model: drives requests, hands in write data two edges late
module ctl_model (
  // clock
  input  wire logic        sys_clk,
  // request lines
  output logic [18:0] addr,
  output logic        chip_en1_n,
  output logic        chip_en2,
  output logic        chip_en3_n,
  output logic        advance_or_load,
  output logic        write_en_n,
  output logic [3:0]  byte_lane_write_n,
  output logic        out_en_n,
  output logic        clock_qualify_n,
  output logic        sleep_request,
  // write data
  output logic [31:0] dq_in,
  output logic [3:0]  parity_in
);
  logic [35:0] p0, p1;
  logic        v0, v1, wburst, wr;

  // called just after a falling edge; a stalled cycle moves nothing
  task automatic drive(input logic adv, input logic [1:0] ce, input logic we_n,
                       input logic [3:0] ln, input logic [18:0] a, input logic [35:0] d,
                       input logic oe_n, stall, slp);
    addr = a;
    advance_or_load = adv;
    write_en_n = we_n;
    byte_lane_write_n = ln;
    out_en_n = oe_n;
    clock_qualify_n = stall;
    sleep_request = slp;
    chip_en1_n = ce == 2'h1;
    chip_en2 = ce != 2'h2;
    chip_en3_n = ce == 2'h3;
    if (slp) begin
      {v0, v1, wburst} = 3'h0;
    end else if (!stall) begin
      wr = adv ? wburst : ce == 2'h0 && !we_n;
      if (!adv) wburst = wr;
      if (v1) {parity_in, dq_in} = p1;
      else {parity_in, dq_in} = ~{parity_in, dq_in}; // released lines never keep a stale value
      {p1, v1} = {p0, v0};
      {p0, v0} = {d, wr};
    end
  endtask

  initial begin
    {parity_in, dq_in} = 36'h0;
    {v0, v1, wburst} = 3'h0;
    drive(1'b1, 2'h1, 1'b1, 4'hf, 19'h0, 36'h0, 1'b0, 1'b0, 1'b0);
  end
endmodule // ctl_model

// [verification/pipelined_burst_sram_tb.sv]
// self-checking bench of the pipelined burst memory block
module pipelined_burst_sram_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic        adv;
    logic [1:0]  ce;
    logic        we_n;
    logic [3:0]  ln;
    logic [18:0] a;
    logic [35:0] d;
    logic        oe_n, stall, slp;
  } row_s;

  logic        sys_clk, resetn, burst_mode, chip_en1_n, chip_en2, chip_en3_n;
  logic        advance_or_load, write_en_n, out_en_n, clock_qualify_n;
  logic        sleep_request, dq_oe, parity_oe, asleep;
  logic [18:0] addr, base;
  logic [31:0] dq_in, dq_out;
  logic [3:0]  byte_lane_write_n, parity_in, parity_out;
  logic [1:0]  cnt, bt;
  logic [37:0] s1, s2;
  logic [35:0] mem [int];
  int          num_errors = 0, n_checks = 0;
  row_s        zz = '{1, 1, 1, 4'hf, 19'h0, 36'h0, 0, 0, 1};
  row_s        rows [18] = '{
    '{0, 0, 0, 4'h0, 19'h101, 36'h1a1b2c3d4, 0, 0, 0},
    '{1, 1, 1, 4'h0, 19'h0, 36'h255667788, 0, 0, 0},
    '{1, 2, 1, 4'ha, 19'h0, 36'h3cafe0123, 0, 0, 0},
    '{1, 3, 0, 4'hf, 19'h0, 36'h4deadbeef, 0, 0, 0},
    '{1, 0, 1, 4'h0, 19'h0, 36'h50f1e2d3c, 0, 0, 0},
    '{0, 0, 1, 4'hf, 19'h101, 36'h0, 0, 0, 0},
    '{1, 1, 0, 4'hf, 19'h0, 36'h0, 0, 1, 0},
    '{1, 1, 0, 4'hf, 19'h0, 36'h0, 0, 0, 0},
    '{1, 0, 0, 4'hf, 19'h0, 36'h0, 1, 0, 0},
    '{1, 0, 1, 4'hf, 19'h0, 36'h0, 1, 0, 0},
    '{1, 0, 1, 4'hf, 19'h0, 36'h0, 0, 0, 0},
    '{0, 0, 0, 4'hf, 19'h101, 36'h6ffffffff, 0, 0, 0},
    '{0, 0, 1, 4'hf, 19'h101, 36'h0, 0, 0, 0},
    '{0, 2, 1, 4'h0, 19'h102, 36'h0, 0, 0, 0},
    '{0, 3, 1, 4'h0, 19'h102, 36'h0, 0, 0, 0},
    '{1, 0, 1, 4'h0, 19'h0, 36'h0, 0, 0, 0},
    '{0, 1, 1, 4'h0, 19'h103, 36'h0, 0, 0, 0},
    '{0, 1, 1, 4'h0, 19'h103, 36'h0, 0, 0, 0}};

  pipelined_burst_sram u_pipelined_burst_sram (.sys_clk, .resetn, .addr, .chip_en1_n,
    .chip_en2, .chip_en3_n, .advance_or_load, .write_en_n, .byte_lane_write_n, .out_en_n,
    .clock_qualify_n, .sleep_request, .burst_mode, .dq_in, .dq_out, .dq_oe, .parity_in,
    .parity_out, .parity_oe, .asleep);
  ctl_model u_ctl_model (.sys_clk, .addr, .chip_en1_n, .chip_en2, .chip_en3_n,
    .advance_or_load, .write_en_n, .byte_lane_write_n, .out_en_n, .clock_qualify_n,
    .sleep_request, .dq_in, .parity_in);

  task automatic chk(input string nm, input logic [35:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // the reference writes at issue, so a read right behind a write sees merged data
  task automatic step(input row_s r);
    logic [18:0] a;
    @(negedge sys_clk);
    chk("dq_oe", s2[37] & ~out_en_n, dq_oe);
    chk("parity_oe", s2[37] & ~out_en_n, parity_oe);
    if (s2[37] && s2[36]) chk("read word", s2[35:0], {parity_out, dq_out});
    if (r.slp) begin
      {s1, s2, bt} = '0;
    end else if (!r.stall) begin
      if (!r.adv) begin
        base = r.a;
        cnt = 2'h0;
        bt = r.ce != 2'h0 ? 2'h0 : r.we_n ? 2'h1 : 2'h2;
      end else cnt++;
      a = {base[18:2], burst_mode ? base[1:0] ^ cnt : base[1:0] + cnt};
      for (int i = 0; i < 4; i++) begin
        if (bt == 2'h2 && !r.ln[i]) begin
          mem[a][8*i +: 8] = r.d[8*i +: 8];
          mem[a][32+i] = r.d[32+i];
        end
      end
      s2 = s1;
      s1 = {bt == 2'h1, mem.exists(a) != 0, mem.exists(a) ? mem[a] : 36'h0};
    end
    u_ctl_model.drive(r.adv, r.ce, r.we_n, r.ln, r.a, r.d, r.oe_n, r.stall, r.slp);
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // the run needs about 60 cycles
  initial begin
    #16000;
    num_errors++;
    give_verdict();
  end

  initial begin
    resetn = 1'b0;
    burst_mode = 1'b1;
    {s1, s2, cnt, bt, base} = '0;
    repeat (5) @(negedge sys_clk);
    chk("dq_oe in reset", 1'b0, dq_oe);
    resetn = 1'b1;
    for (int m = 1; m >= 0; m--) begin
      burst_mode = m[0];
      foreach (rows[i]) step(rows[i]);
    end
    repeat (3) step(zz);
    @(negedge sys_clk);
    chk("asleep", 1'b1, asleep);
    chk("dq_oe asleep", 1'b0, dq_oe);
    repeat (4) step(rows[17]);
    chk("asleep after wake", 1'b0, asleep);
    step(rows[12]);
    step(rows[17]);
    step(rows[17]);
    // reset in mid-read with the output enable on: drivers must fall
    step(rows[12]);
    @(negedge sys_clk);
    resetn = 1'b0;
    u_ctl_model.drive(1'b0, 2'h1, 1'b1, 4'h0, 19'h103, 36'h0, 1'b0, 1'b0, 1'b0);
    {s1, s2, bt} = '0;
    repeat (2) @(negedge sys_clk);
    chk("dq_oe mid reset", 1'b0, dq_oe);
    chk("asleep mid reset", 1'b0, asleep);
    resetn = 1'b1;
    step(rows[12]);
    step(rows[17]);
    step(rows[17]);
    give_verdict();
  end
endmodule // pipelined_burst_sram_tb
